// ===== hdl/priv_decode_cfg.svh
`ifndef PRIV_DECODE_CFG_SVH
`define PRIV_DECODE_CFG_SVH

// register byte offsets
`define OFS_CONTROL      12'h000
`define OFS_STATUS       12'h004
`define OFS_INT_STATUS   12'h008
`define OFS_INT_CLEAR    12'h00C
`define OFS_INT_ENABLE   12'h010
`define OFS_LAST_ADDR    12'h014
`define OFS_LAST_DECODE  12'h018

// control register fields
`define CTL_KERNEL_HWE   0
`define CTL_KERNEL_MODE  1
`define CTL_RESET_VALUE  32'h0000_0000

// instruction fields
`define OPC_HI           31
`define OPC_LO           26
`define DEST_HI          25
`define DEST_LO          21
`define BASE_HI          20
`define BASE_LO          16
`define TYPE_HI          15
`define TYPE_LO          13
`define SIZE_BIT         12
`define DISPLACEMENT_FIELD_HI          11
`define FUNC_HI          25

// major opcodes
`define OPC_FW_CALL      6'h00
`define OPC_INT_RD       6'h19
`define OPC_PRIV_LD      6'h1B
`define OPC_INT_WR       6'h1D
`define OPC_PRIV_RET     6'h1E
`define OPC_PRIV_ST      6'h1F

// firmware-call function codes
`define FN_STOP          26'h000_0000
`define FN_DRAIN         26'h000_0002
`define FN_IMB           26'h000_0086

// interrupt status bits
`define IRQ_ILLEGAL      0
`define IRQ_ENTRY        1
`define IRQ_RETURN       2
`define IRQ_WIDTH        3

`endif

// ===== hdl/priv_decode_pkg.sv
package priv_decode_pkg;

    typedef enum logic [2:0]
    {
        LD_PHYS,
        LD_PHYS_LOCK,
        VIRTUAL_PTE_FETCH,
        LD_RSVD,
        LD_VIRT,
        LD_VIRT_CHK,
        LD_VIRT_ALT,
        LD_VIRT_CHK_ALT
    } load_type_t;

    typedef enum logic [3:0]
    {
        CLS_NONE,
        CLS_PRIV_LOAD,
        CLS_PRIV_STORE,
        CLS_PRIV_RETURN,
        CLS_INT_READ,
        CLS_INT_WRITE,
        CLS_STOP,
        CLS_DRAIN,
        CLS_IMB,
        CLS_FW_CALL,
        CLS_ILLEGAL
    } instr_class_t;

    typedef enum logic [1:0]
    {
        MODE_NORMAL,
        MODE_FIRMWARE
    } exec_mode_t;

endpackage

// ===== hdl/privileged_mode_decode.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "priv_decode_cfg.svh"

module privileged_mode_decode
#(
    parameter int ADDR_W = 64
)
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic                              irq,
    input  wire logic                         issue_valid,
    input  wire logic [31:0]                  issue_instr,
    input  wire logic [ADDR_W-1:0]            base_value,
    input  wire logic                         ret_mode_bit,
    input  wire logic                         machine_check,
    input  wire logic                         arithmetic_exception,
    input  wire logic                         mm_exception,
    input  wire logic                         ext_interrupt,
    output logic                              firmware_mode,
    output logic                              fetch_translate,
    output logic                              data_translate,
    output logic                              interrupt_taken,
    output logic                              mode_entry,
    output logic                              illegal_opcode_entry,
    output logic                              exec_valid,
    output priv_decode_pkg::instr_class_t     exec_class,
    output logic [4:0]                        dest_reg_field,
    output logic [4:0]                        base_reg_field,
    output logic [ADDR_W-1:0]                 eff_addr,
    output logic                              access_quad,
    output logic                              addr_physical,
    output logic                              load_lock,
    output logic                              virtual_pte_fetch,
    output logic                              kernel_check,
    output logic                              fault_on_write,
    output logic                              alt_mode_check,
    output logic                              align_trap_allow
);
    import priv_decode_pkg::*;

    if (ADDR_W < 32 || ADDR_W > 64)
    begin : g_bad_addr_w
        $error("ADDR_W must be 32 to 64");
    end

    logic [31:0]              control_reg;
    logic [`IRQ_WIDTH-1:0]    int_status_reg;
    logic [`IRQ_WIDTH-1:0]    int_enable_reg;
    logic [ADDR_W-1:0]        last_addr_reg;
    exec_mode_t               mode_reg;
    logic                     mch_s1, mch_s2, ari_s1, ari_s2, mme_s1, mme_s2, int_s1, int_s2;

    // decode helpers
    function automatic logic is_restricted(input logic [5:0] opc);
        is_restricted = (opc == `OPC_PRIV_LD) || (opc == `OPC_PRIV_ST) ||
                        (opc == `OPC_PRIV_RET) || (opc == `OPC_INT_RD) ||
                        (opc == `OPC_INT_WR);
    endfunction

    function automatic instr_class_t classify(input logic [31:0] ins);
        logic [5:0]  opc;
        logic [25:0] fn;
        opc = ins[`OPC_HI:`OPC_LO];
        fn  = ins[`FUNC_HI:0];
        if (opc == `OPC_PRIV_LD)
            classify = CLS_PRIV_LOAD;
        else if (opc == `OPC_PRIV_ST)
            classify = CLS_PRIV_STORE;
        else if (opc == `OPC_PRIV_RET)
            classify = CLS_PRIV_RETURN;
        else if (opc == `OPC_INT_RD)
            classify = CLS_INT_READ;
        else if (opc == `OPC_INT_WR)
            classify = CLS_INT_WRITE;
        else if (opc == `OPC_FW_CALL && fn == `FN_STOP)
            classify = CLS_STOP;
        else if (opc == `OPC_FW_CALL && fn == `FN_DRAIN)
            classify = CLS_DRAIN;
        else if (opc == `OPC_FW_CALL && fn == `FN_IMB)
            classify = CLS_IMB;
        else if (opc == `OPC_FW_CALL)
            classify = CLS_FW_CALL;
        else
            classify = CLS_NONE;
    endfunction

    // exception inputs synchronised
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {mch_s1, mch_s2, ari_s1, ari_s2} <= 4'h0;
            {mme_s1, mme_s2, int_s1, int_s2} <= 4'h0;
        end
        else
        begin
            mch_s1 <= machine_check;
            mch_s2 <= mch_s1;
            ari_s1 <= arithmetic_exception;
            ari_s2 <= ari_s1;
            mme_s1 <= mm_exception;
            mme_s2 <= mme_s1;
            int_s1 <= ext_interrupt;
            int_s2 <= int_s1;
        end
    end

    logic         in_fw;
    logic         kern_ok;
    logic [5:0]   cur_opc;
    instr_class_t cur_cls;
    logic         privileged_call;
    logic         illegal_now;
    logic         int_req;
    logic         hw_exc;
    logic         call_entry;
    logic         entry_now;
    logic         ret_now;

    assign in_fw           = (mode_reg == MODE_FIRMWARE);
    assign kern_ok         = control_reg[`CTL_KERNEL_HWE] && control_reg[`CTL_KERNEL_MODE];
    assign cur_opc         = issue_instr[`OPC_HI:`OPC_LO];
    assign cur_cls         = classify(issue_instr);
    assign privileged_call = (cur_cls == CLS_STOP) || (cur_cls == CLS_DRAIN);
    assign illegal_now     = issue_valid && !in_fw && !kern_ok &&
                             (is_restricted(cur_opc) || privileged_call);
    assign int_req         = int_s2 && !in_fw;
    assign hw_exc          = mch_s2 || ari_s2 || mme_s2;
    assign call_entry      = issue_valid && (cur_cls == CLS_FW_CALL || cur_cls == CLS_IMB ||
                             (privileged_call && !illegal_now));
    assign entry_now       = hw_exc || int_req || call_entry || illegal_now;
    assign ret_now         = issue_valid && !illegal_now && (cur_cls == CLS_PRIV_RETURN);

    // execution mode: reset enters firmware mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_reg <= MODE_FIRMWARE;
        else if (entry_now)
            mode_reg <= MODE_FIRMWARE;
        else if (ret_now)
            mode_reg <= ret_mode_bit ? MODE_FIRMWARE : MODE_NORMAL;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            firmware_mode        <= 1'b1;
            fetch_translate      <= 1'b0;
            data_translate       <= 1'b1;
            interrupt_taken      <= 1'b0;
            mode_entry           <= 1'b0;
            illegal_opcode_entry <= 1'b0;
        end
        else
        begin
            firmware_mode        <= entry_now || (ret_now ? ret_mode_bit : in_fw);
            fetch_translate      <= !(entry_now || (ret_now ? ret_mode_bit : in_fw));
            data_translate       <= 1'b1;
            interrupt_taken      <= int_req;
            mode_entry           <= entry_now;
            illegal_opcode_entry <= illegal_now;
        end
    end

    // privileged load field decode
    logic [ADDR_W-1:0] displacement_field_ext;
    load_type_t        ld_type;
    logic              is_load;
    assign displacement_field_ext = {{(ADDR_W-12){issue_instr[`DISPLACEMENT_FIELD_HI]}}, issue_instr[`DISPLACEMENT_FIELD_HI:0]};
    assign ld_type  = load_type_t'(issue_instr[`TYPE_HI:`TYPE_LO]);
    assign is_load  = (cur_cls == CLS_PRIV_LOAD);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exec_valid        <= 1'b0;
            exec_class        <= CLS_NONE;
            dest_reg_field    <= 5'h00;
            base_reg_field    <= 5'h00;
            eff_addr          <= '0;
            access_quad       <= 1'b0;
            addr_physical     <= 1'b0;
            load_lock         <= 1'b0;
            virtual_pte_fetch <= 1'b0;
            kernel_check      <= 1'b0;
            fault_on_write    <= 1'b0;
            alt_mode_check    <= 1'b0;
            align_trap_allow  <= 1'b1;
        end
        else
        begin
            exec_valid        <= issue_valid && !illegal_now;
            exec_class        <= illegal_now ? CLS_ILLEGAL : cur_cls;
            dest_reg_field    <= issue_instr[`DEST_HI:`DEST_LO];
            base_reg_field    <= issue_instr[`BASE_HI:`BASE_LO];
            eff_addr          <= base_value + displacement_field_ext;
            access_quad       <= issue_instr[`SIZE_BIT];
            addr_physical     <= is_load && (ld_type == LD_PHYS ||
                                 ld_type == LD_PHYS_LOCK);
            load_lock         <= is_load && ld_type == LD_PHYS_LOCK;
            virtual_pte_fetch <= is_load && ld_type == VIRTUAL_PTE_FETCH;
            kernel_check      <= is_load && ld_type == VIRTUAL_PTE_FETCH;
            fault_on_write    <= is_load && (ld_type == LD_VIRT_CHK ||
                                 ld_type == LD_VIRT_CHK_ALT);
            alt_mode_check    <= is_load && (ld_type == LD_VIRT_ALT ||
                                 ld_type == LD_VIRT_CHK_ALT);
            align_trap_allow  <= !(issue_valid && is_load);
        end
    end

    // last load address, low 32 bits readable by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_addr_reg <= '0;
        else if (issue_valid && is_load && !illegal_now)
            last_addr_reg <= base_value + displacement_field_ext;
    end

    // apb slave
    logic wr_acc, rd_acc, bad_addr;
    assign wr_acc   = psel && penable && pwrite;
    assign rd_acc   = psel && penable && !pwrite;
    assign bad_addr = !(paddr == `OFS_CONTROL || paddr == `OFS_STATUS ||
                        paddr == `OFS_INT_STATUS || paddr == `OFS_INT_CLEAR ||
                        paddr == `OFS_INT_ENABLE || paddr == `OFS_LAST_ADDR ||
                        paddr == `OFS_LAST_DECODE);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_reg    <= `CTL_RESET_VALUE;
            int_enable_reg <= '0;
        end
        else if (wr_acc && pready)
        begin
            if (paddr == `OFS_CONTROL)
                control_reg <= {30'h0, pwdata[1:0]};
            else if (paddr == `OFS_INT_ENABLE)
                int_enable_reg <= pwdata[`IRQ_WIDTH-1:0];
        end
    end

    logic [`IRQ_WIDTH-1:0] ev_set, ev_clr;
    assign ev_set = {ret_now, entry_now, illegal_now};
    assign ev_clr = (wr_acc && pready && paddr == `OFS_INT_CLEAR) ?
                    pwdata[`IRQ_WIDTH-1:0] : '0;

    // set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_status_reg <= '0;
        else
            int_status_reg <= (int_status_reg & ~ev_clr) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(((int_status_reg & ~ev_clr) | ev_set) & int_enable_reg);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && bad_addr;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                if (paddr == `OFS_CONTROL)
                    prdata <= control_reg;
                else if (paddr == `OFS_STATUS)
                    prdata <= {30'h0, !fetch_translate, firmware_mode};
                else if (paddr == `OFS_INT_STATUS)
                    prdata <= {29'h0, int_status_reg};
                else if (paddr == `OFS_INT_ENABLE)
                    prdata <= {29'h0, int_enable_reg};
                else if (paddr == `OFS_LAST_ADDR)
                    prdata <= last_addr_reg[31:0];
                else if (paddr == `OFS_LAST_DECODE)
                    prdata <= {28'h0, exec_class};
            end
        end
    end

    // checks
    default clocking cb_chk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_int_accepted;
        int_s2 && !in_fw;
    endsequence

    sequence seq_fw_entered;
        in_fw && interrupt_taken && mode_entry;
    endsequence

    chk_illegal_blocks_exec: assert property
        (illegal_now |=> illegal_opcode_entry && !exec_valid && firmware_mode)
        else $error("illegal opcode was executed");
    chk_kernel_enable_ok: assert property
        ((issue_valid && kern_ok && is_restricted(cur_opc)) |=> !illegal_opcode_entry)
        else $error("kernel enable ignored");
    chk_fw_fetch_untranslated: assert property
        (firmware_mode |-> !fetch_translate && data_translate)
        else $error("translation wrong in firmware mode");
    chk_no_interrupt_fw: assert property
        ($past(in_fw) |-> !interrupt_taken)
        else $error("interrupt taken in firmware mode");
    chk_entry_on_exc: assert property
        (hw_exc |=> in_fw)
        else $error("exception did not enter firmware mode");
    chk_load_addr_sum: assert property
        (issue_valid |=> eff_addr == $past(base_value) +
            {{(ADDR_W-12){$past(issue_instr[11])}}, $past(issue_instr[11:0])})
        else $error("effective address wrong");
    chk_lock_is_phys: assert property
        (load_lock |-> addr_physical && !alt_mode_check)
        else $error("locked load not physical");
    chk_no_align_trap: assert property
        ((issue_valid && is_load) |=> !align_trap_allow)
        else $error("alignment trap allowed on load");
    chk_int_enters_fw: assert property
        (seq_int_accepted |=> seq_fw_entered)
        else $error("interrupt did not enter firmware mode");
    chk_return_sets_mode: assert property
        ((ret_now && !entry_now) |=> firmware_mode == $past(ret_mode_bit))
        else $error("return left wrong mode");
    chk_load_fields: assert property
        (issue_valid |=> dest_reg_field == $past(issue_instr[`DEST_HI:`DEST_LO]) &&
            base_reg_field == $past(issue_instr[`BASE_HI:`BASE_LO]))
        else $error("register fields wrong");
    chk_size_select: assert property
        (issue_valid |=> access_quad == $past(issue_instr[`SIZE_BIT]))
        else $error("access size wrong");
endmodule

// ===== test/issue_side_model.sv
`timescale 1ns/1ps
// integer register file seen by the issue stage; bit0 of odd registers is set
module issue_side_model
(
    input  wire logic [31:0] issue_instr,
    output logic      [63:0] base_value,
    output logic             ret_mode_bit
);
    logic [63:0] regs [32];

    initial
    begin
        for (int i = 0; i < 32; i++)
            regs[i] = (64'(i) << 12) | 64'(i % 2);
    end

    assign base_value   = regs[issue_instr[20:16]];
    assign ret_mode_bit = base_value[0];
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
`include "priv_decode_cfg.svh"
module tb_top;
    import priv_decode_pkg::*;
    typedef struct {logic [31:0] ins; instr_class_t cls;} row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ret_mode_bit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, issue_instr, rd;
    logic [63:0] base_value, eff_addr;
    logic issue_valid, machine_check, arithmetic_exception, mm_exception, ext_interrupt;
    logic firmware_mode, fetch_translate, data_translate, interrupt_taken, mode_entry;
    logic illegal_opcode_entry, exec_valid, access_quad, addr_physical, load_lock;
    logic virtual_pte_fetch, kernel_check, fault_on_write, alt_mode_check, align_trap_allow;
    logic [4:0] dest_reg_field, base_reg_field;
    logic err, ld, hit, tk;
    logic [2:0] ty;
    instr_class_t exec_class;
    int err_count, checked;
    row_t rows[15];
    logic [5:0] flag_tab [8] = '{6'h20, 6'h30, 6'h0C, 6'h00, 6'h00, 6'h02, 6'h01, 6'h03};
    logic [31:0] bad [7] = '{32'h6400_0000, 32'h6C00_0000, 32'h7400_0000, 32'h7800_0000,
                             32'h7C00_0000, 32'h0000_0000, 32'h0000_0002};

    privileged_mode_decode dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .issue_valid, .issue_instr, .base_value,
        .ret_mode_bit, .machine_check, .arithmetic_exception, .mm_exception, .ext_interrupt,
        .firmware_mode, .fetch_translate, .data_translate, .interrupt_taken, .mode_entry,
        .illegal_opcode_entry, .exec_valid, .exec_class, .dest_reg_field, .base_reg_field,
        .eff_addr, .access_quad, .addr_physical, .load_lock, .virtual_pte_fetch,
        .kernel_check, .fault_on_write, .alt_mode_check, .align_trap_allow);
    issue_side_model partner_u (.issue_instr, .base_value, .ret_mode_bit);

    initial
    begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end

    task check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task issue(input logic [31:0] ins);
        @(posedge pclk);
        issue_valid <= 1;
        issue_instr <= ins;
        @(posedge pclk);
        issue_valid <= 0;
        #1;
    endtask

    task to_normal;
        issue(32'h7BE2_0000);
        @(posedge pclk);
        #1;
        check(firmware_mode, 0);
        check(fetch_translate, 1);
    endtask

    initial
    begin
        repeat (5000) @(posedge pclk);
        err_count++;
        wrap_up;
    end

    initial
    begin
        {presetn, psel, penable, pwrite, issue_valid, paddr, pwdata, issue_instr} = '0;
        {machine_check, arithmetic_exception, mm_exception, ext_interrupt} = 4'h0;
        for (int i = 0; i < 8; i++)
            rows[i] = '{{6'h1B, 5'(i + 1), 5'(i + 2), 3'(i), i[0],
                        (i % 2) ? 12'(12'h800 | i) : 12'(12'h7F0 | i)}, CLS_PRIV_LOAD};
        rows[8]  = '{32'h7C00_0000, CLS_PRIV_STORE};
        rows[9]  = '{32'h6400_0000, CLS_INT_READ};
        rows[10] = '{32'h7400_0000, CLS_INT_WRITE};
        rows[11] = '{32'h0000_0000, CLS_STOP};
        rows[12] = '{32'h0000_0002, CLS_DRAIN};
        rows[13] = '{32'h0000_0086, CLS_IMB};
        rows[14] = '{32'h4000_0000, CLS_NONE};
        repeat (10) @(posedge pclk);
        check(firmware_mode, 1);
        check({data_translate, fetch_translate, align_trap_allow, irq}, 4'hA);
        presetn <= 1;
        apb(0, `OFS_CONTROL, 0);
        check(rd, `CTL_RESET_VALUE);
        apb(0, `OFS_STATUS, 0);
        check(rd[1:0], 2'b11);
        apb(1, `OFS_INT_ENABLE, 32'h7);
        apb(0, `OFS_INT_ENABLE, 0);
        check(rd, 32'h7);
        apb(0, 12'h020, 0);
        check({err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 15; i++)
        begin
            issue(rows[i].ins);
            ld = rows[i].ins[31:26] == 6'h1B;
            ty = rows[i].ins[15:13];
            check(exec_valid, 1);
            check(exec_class, rows[i].cls);
            check({addr_physical, load_lock, virtual_pte_fetch, kernel_check, fault_on_write,
                   alt_mode_check}, ld ? flag_tab[ty] : 6'h00);
            check(access_quad, ld & rows[i].ins[12]);
            if (ld)
            begin
                check(dest_reg_field, rows[i].ins[25:21]);
                check(base_reg_field, rows[i].ins[20:16]);
                check(eff_addr, partner_u.regs[rows[i].ins[20:16]]
                      + {{52{rows[i].ins[11]}}, rows[i].ins[11:0]});
                check(align_trap_allow, 0);
            end
        end
        check({firmware_mode, fetch_translate, data_translate}, 3'b101);
        apb(0, `OFS_LAST_ADDR, 0);
        check(rd, 32'h0000_8808);
        ext_interrupt <= 1;
        repeat (8)
        begin
            @(posedge pclk);
            #1;
            check(interrupt_taken, 0);
        end
        ext_interrupt <= 0;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 7; i++)
        begin
            to_normal;
            issue(bad[i]);
            check({illegal_opcode_entry, exec_valid}, 2'b10);
            check(exec_class, CLS_ILLEGAL);
            @(posedge pclk);
            #1;
            check(firmware_mode, 1);
        end
        check(irq, 1);
        apb(1, `OFS_INT_ENABLE, 0);
        @(posedge pclk);
        #1;
        check(irq, 0);
        apb(1, `OFS_INT_CLEAR, 32'h7);
        apb(0, `OFS_INT_STATUS, 0);
        check(rd, 0);
        to_normal;
        issue(32'h0000_0086);
        check({exec_valid, illegal_opcode_entry}, 2'b10);
        for (int k = 0; k < 4; k++)
        begin
            to_normal;
            @(posedge pclk);
            {machine_check, arithmetic_exception, mm_exception, ext_interrupt} <= 4'h8 >> k;
            hit = 0;
            tk = 0;
            repeat (10)
            begin
                @(posedge pclk);
                #1;
                if (mode_entry === 1'b1)
                    hit = 1;
                if (interrupt_taken === 1'b1)
                    tk = 1;
            end
            @(posedge pclk);
            {machine_check, arithmetic_exception, mm_exception, ext_interrupt} <= 4'h0;
            check(hit, 1);
            check(tk, k == 3);
            check(firmware_mode, 1);
            repeat (4) @(posedge pclk);
        end
        apb(1, `OFS_CONTROL, 32'h3);
        to_normal;
        issue(32'h6400_0000);
        check({exec_valid, illegal_opcode_entry}, 2'b10);
        check(exec_class, CLS_INT_READ);
        @(posedge pclk);
        presetn <= 0;
        @(posedge pclk);
        #1;
        check(firmware_mode, 1);
        @(posedge pclk);
        presetn <= 1;
        apb(0, `OFS_CONTROL, 0);
        check(rd, `CTL_RESET_VALUE);
        check({firmware_mode, fetch_translate}, 2'b10);
        wrap_up;
    end
endmodule
